// >>> include/mmd_map.svh
// address bounds and selection codes for the internal memory map decoder
`ifndef MMD_MAP_SVH
`define MMD_MAP_SVH

// ****************************************************************
// mapping selection codes
// ****************************************************************
`define MMD_SEL_LOW      4'h0
`define MMD_SEL_HIGH     4'hf

// ****************************************************************
// internal data area, low placement
// ****************************************************************
`define MMD_DLO_L_V12    20'h0f700
`define MMD_DLO_L_V3     20'h0f100
`define MMD_DLO_L_V4     20'h0ee00
`define MMD_DHI_L        20'h0ffff

// ****************************************************************
// internal data area, top placement (runs to the end of space)
// ****************************************************************
`define MMD_DLO_H_V12    20'hff700
`define MMD_DLO_H_V3     20'hff100
`define MMD_DLO_H_V4     20'hfee00

// ****************************************************************
// internal rom, low placement (first window starts at zero)
// ****************************************************************
`define MMD_R0HI_L_V1    20'h0bfff
`define MMD_R0HI_L_V2    20'h0f6ff
`define MMD_R0HI_L_V3    20'h0f0ff
`define MMD_R0HI_L_V4    20'h0fdff
`define MMD_R1LO         20'h10000
`define MMD_R1HI_V3      20'h17fff
`define MMD_R1HI_V4      20'h1ffff

// ****************************************************************
// internal rom, top placement (one window from zero)
// ****************************************************************
`define MMD_RHI_H_V1     20'h0bfff
`define MMD_RHI_H_V2     20'h0ffff
`define MMD_RHI_H_V3     20'h17fff
`define MMD_RHI_H_V4     20'h1ffff

`endif

// >>> include/mmd_pkg.sv
// types shared by the internal memory map decoder
`default_nettype none
package mmd_pkg;
    typedef logic [19:0] mmd_addr_t;   // 1 Mbyte linear address
    typedef logic [3:0]  mmd_sel_t;    // mapping selection operand

    // product variant, by internal rom size
    typedef enum logic [1:0] {
        MMD_V48K,
        MMD_V64K,
        MMD_V96K,
        MMD_V128K
    } mmd_variant_e;

    // mapping state since reset
    typedef enum logic [1:0] {
        MMD_MAP_UNSET,
        MMD_MAP_LOW,
        MMD_MAP_HIGH
    } mmd_map_e;
endpackage : mmd_pkg
`default_nettype wire

// >>> include/mmd_dec_if.sv
// carrier between the decoder top and its region lookup
`timescale 1ns/10ps
`default_nettype none
interface mmd_dec_if;
    import mmd_pkg::*;
    mmd_addr_t addr;       // address under decode
    logic      map_high;   // data area at the top of space
    logic      data_hit;   // address in internal data area
    logic      rom_hit;    // address in internal rom (raw)

    modport dec  (input addr, input map_high, output data_hit, output rom_hit);
    modport core (output addr, output map_high, input data_hit, input rom_hit);
endinterface : mmd_dec_if
`default_nettype wire

// >>> logic/mmd_region_dec.sv
// region lookup: data area and rom windows for one variant
`timescale 1ns/10ps
`default_nettype none
`include "mmd_map.svh"
module mmd_region_dec #(
    parameter mmd_pkg::mmd_variant_e VARIANT = mmd_pkg::MMD_V128K
) (
    mmd_dec_if.dec dif
);
    import mmd_pkg::*;

    // ****************************************************************
    // variant table, resolved at elaboration
    // ****************************************************************
    localparam mmd_addr_t DLO_L = (VARIANT == MMD_V96K)  ? `MMD_DLO_L_V3 :
                                  (VARIANT == MMD_V128K) ? `MMD_DLO_L_V4 : `MMD_DLO_L_V12;
    localparam mmd_addr_t DLO_H = (VARIANT == MMD_V96K)  ? `MMD_DLO_H_V3 :
                                  (VARIANT == MMD_V128K) ? `MMD_DLO_H_V4 : `MMD_DLO_H_V12;
    localparam mmd_addr_t R0HI_L = (VARIANT == MMD_V48K) ? `MMD_R0HI_L_V1 :
                                   (VARIANT == MMD_V64K) ? `MMD_R0HI_L_V2 :
                                   (VARIANT == MMD_V96K) ? `MMD_R0HI_L_V3 : `MMD_R0HI_L_V4;
    localparam mmd_addr_t R1HI_L = (VARIANT == MMD_V96K) ? `MMD_R1HI_V3 : `MMD_R1HI_V4;
    localparam logic      R1_EN  = (VARIANT == MMD_V96K) || (VARIANT == MMD_V128K);
    localparam mmd_addr_t RHI_H = (VARIANT == MMD_V48K) ? `MMD_RHI_H_V1 :
                                  (VARIANT == MMD_V64K) ? `MMD_RHI_H_V2 :
                                  (VARIANT == MMD_V96K) ? `MMD_RHI_H_V3 : `MMD_RHI_H_V4;

    // ****************************************************************
    // window compares
    // ****************************************************************
    wire logic data_lo_hit;   // low placement data window
    wire logic data_hi_hit;   // top placement runs to end of space
    wire logic rom_lo_hit;    // split rom, may overlap data window
    wire logic rom_hi_hit;    // contiguous rom from zero

    assign data_lo_hit  = (dif.addr >= DLO_L) && (dif.addr <= `MMD_DHI_L);
    assign data_hi_hit  = (dif.addr >= DLO_H);
    assign rom_lo_hit   = (dif.addr <= R0HI_L)
                        || (R1_EN && (dif.addr >= `MMD_R1LO) && (dif.addr <= R1HI_L));
    assign rom_hi_hit   = (dif.addr <= RHI_H);
    assign dif.data_hit = dif.map_high ? data_hi_hit : data_lo_hit;
    assign dif.rom_hit  = dif.map_high ? rom_hi_hit : rom_lo_hit;
endmodule : mmd_region_dec
`default_nettype wire

// >>> logic/mmd_decoder.sv
// internal memory map decoder: one-time placement, access steering
`timescale 1ns/10ps
`default_nettype none
`include "mmd_map.svh"

// Summary of operation
// - decode every core access over 20-bit space
// - selection places data area and rom
// - setting 0: data area below 10000h
// - setting 0: rom windows per variant
// - setting 0: rom under data area hidden
// - unclaimed goes external only in expansion mode
// - setting 0fh: data area at top
// - setting 0fh: rom contiguous from zero
module mmd_decoder #(
    parameter mmd_pkg::mmd_variant_e VARIANT = mmd_pkg::MMD_V128K
) (
    input  wire logic              clk_i,              // 40 MHz system clock
    input  wire logic              rst_i,              // synchronous, active high
    input  wire logic              map_sel_valid_i,    // core executes selection
    input  wire mmd_pkg::mmd_sel_t data_area_map_select_i, // selection operand
    input  wire logic              acc_valid_i,        // core access request
    input  wire mmd_pkg::mmd_addr_t acc_addr_i,        // core access address
    input  wire logic              ext_mode_i,         // expansion mode active
    output var  logic              out_valid_o,        // decode result valid
    output var  mmd_pkg::mmd_addr_t addr_o,            // address of the result
    output var  logic              sel_data_o,         // internal data area
    output var  logic              sel_rom_o,          // internal rom
    output var  logic              sel_ext_o,          // external memory
    output var  logic              sel_fault_o,        // nothing claims it
    output var  logic              map_done_o,         // selection taken
    output var  logic              map_high_o          // top placement active
);
    import mmd_pkg::*;

    // ****************************************************************
    // mapping state
    // ****************************************************************
    mmd_map_e  state;          // placement since reset
    mmd_map_e  next_state;     // placement after this cycle
    wire logic sel_is_low;     // operand is setting 0
    wire logic sel_is_high;    // operand is setting 0fh
    wire logic map_is_high;    // current placement is top

    assign sel_is_low  = (data_area_map_select_i == `MMD_SEL_LOW);
    assign sel_is_high = (data_area_map_select_i == `MMD_SEL_HIGH);
    assign map_is_high = (state == MMD_MAP_HIGH);

    // first legal selection wins, later ones fall on deaf ears
    always_comb
    begin
        next_state = state;
        unique case (state)
            MMD_MAP_UNSET:
            begin
                // unknown operands are ignored so a later good one still lands
                if (map_sel_valid_i && sel_is_low)
                    next_state = MMD_MAP_LOW;
                else if (map_sel_valid_i && sel_is_high)
                    next_state = MMD_MAP_HIGH;
            end
            MMD_MAP_LOW,
            MMD_MAP_HIGH:
                next_state = state;
            // the spare fourth code falls back to no selection
            default:
                next_state = MMD_MAP_UNSET;
        endcase
    end

    // placement register; before selection the low placement applies
    always_ff @(posedge clk_i)
    begin
        if (rst_i)
            state <= MMD_MAP_UNSET;
        else
            state <= next_state;
    end

    // ****************************************************************
    // region lookup
    // ****************************************************************
    mmd_dec_if dif ();         // carrier to the lookup

    assign dif.addr     = acc_addr_i;      // full 20 bits decoded
    assign dif.map_high = map_is_high;

    mmd_region_dec #(
        .VARIANT (VARIANT)
    ) u_region (
        .dif (dif.dec)
    );

    // ****************************************************************
    // steering decision
    // ****************************************************************
    wire logic next_data;      // data area claims it
    wire logic next_rom;       // rom claims it, data not
    wire logic claimed;        // any internal area claims it
    wire logic next_ext;       // goes to external memory
    wire logic next_fault;     // no target at all

    assign next_data  = acc_valid_i && dif.data_hit;
    // data wins: this is also what hides rom under the data area
    assign next_rom   = acc_valid_i && dif.rom_hit && !dif.data_hit;
    assign claimed    = dif.data_hit || dif.rom_hit;
    assign next_ext   = acc_valid_i && !claimed && ext_mode_i;
    assign next_fault = acc_valid_i && !claimed && !ext_mode_i;

    // one-cycle registered result keeps outputs glitch free
    always_ff @(posedge clk_i)
    begin
        if (rst_i)
        begin
            out_valid_o <= 1'b0;
            addr_o      <= 20'h00000;
            sel_data_o  <= 1'b0;
            sel_rom_o   <= 1'b0;
            sel_ext_o   <= 1'b0;
            sel_fault_o <= 1'b0;
            map_done_o  <= 1'b0;
            map_high_o  <= 1'b0;
        end
        else
        begin
            out_valid_o <= acc_valid_i;
            addr_o      <= acc_addr_i;
            sel_data_o  <= next_data;
            sel_rom_o   <= next_rom;
            sel_ext_o   <= next_ext;
            sel_fault_o <= next_fault;
            map_done_o  <= (next_state != MMD_MAP_UNSET);
            map_high_o  <= (next_state == MMD_MAP_HIGH);
        end
    end

    // ****************************************************************
    // checks: expected windows, kept apart from the lookup table
    // ****************************************************************
    localparam mmd_addr_t CHK_DLO_L = (VARIANT == MMD_V96K)  ? `MMD_DLO_L_V3 :
                                      (VARIANT == MMD_V128K) ? `MMD_DLO_L_V4 : `MMD_DLO_L_V12;
    localparam mmd_addr_t CHK_DLO_H = (VARIANT == MMD_V96K)  ? `MMD_DLO_H_V3 :
                                      (VARIANT == MMD_V128K) ? `MMD_DLO_H_V4 : `MMD_DLO_H_V12;
    localparam mmd_addr_t CHK_RHI_H = (VARIANT == MMD_V48K) ? `MMD_RHI_H_V1 :
                                      (VARIANT == MMD_V64K) ? `MMD_RHI_H_V2 :
                                      (VARIANT == MMD_V96K) ? `MMD_RHI_H_V3 : `MMD_RHI_H_V4;
    localparam mmd_addr_t CHK_R0HI_L = (VARIANT == MMD_V48K) ? `MMD_R0HI_L_V1 :
                                       (VARIANT == MMD_V64K) ? `MMD_R0HI_L_V2 :
                                       (VARIANT == MMD_V96K) ? `MMD_R0HI_L_V3 : `MMD_R0HI_L_V4;
    localparam mmd_addr_t CHK_R1HI   = (VARIANT == MMD_V96K) ? `MMD_R1HI_V3 : `MMD_R1HI_V4;
    localparam logic      CHK_R1_EN  = (VARIANT == MMD_V96K) || (VARIANT == MMD_V128K); // upper rom window exists

    // a selection that is taken, then a second one offered
    sequence s_first_select;
        map_sel_valid_i && (sel_is_low || sel_is_high) && (state == MMD_MAP_UNSET);
    endsequence
    sequence s_later_select;
        ##[1:8] map_sel_valid_i;
    endsequence
    // an access taken under each placement
    sequence s_low_access;
        acc_valid_i && !map_is_high;
    endsequence
    sequence s_high_access;
        acc_valid_i && map_is_high;
    endsequence

    a_one_hot_target: assert property (@(posedge clk_i) disable iff (rst_i)
        out_valid_o |-> $onehot({sel_data_o, sel_rom_o, sel_ext_o, sel_fault_o}))
        else $error("access result not one-hot");
    a_select_sticks: assert property (@(posedge clk_i) disable iff (rst_i)
        s_first_select ##0 s_later_select |=> $stable(map_high_o) && map_done_o)
        else $error("placement changed after first selection");
    a_select_lands: assert property (@(posedge clk_i) disable iff (rst_i)
        s_first_select |=> map_done_o && (map_high_o == $past(sel_is_high)))
        else $error("first selection not taken");
    a_low_data_area: assert property (@(posedge clk_i) disable iff (rst_i)
        acc_valid_i && !map_is_high && acc_addr_i >= CHK_DLO_L && acc_addr_i <= `MMD_DHI_L
        |=> sel_data_o && !sel_rom_o)
        else $error("low data window missed");
    a_low_rom_base: assert property (@(posedge clk_i) disable iff (rst_i)
        acc_valid_i && !map_is_high && acc_addr_i < CHK_DLO_L && acc_addr_i <= `MMD_R0HI_L_V1
        |=> sel_rom_o)
        else $error("low rom base missed");
    a_hidden_rom: assert property (@(posedge clk_i) disable iff (rst_i)
        out_valid_o && !$past(map_is_high) && addr_o >= CHK_DLO_L && addr_o <= `MMD_DHI_L
        |-> !sel_rom_o)
        else $error("rom reachable under data area");
    a_ext_gating: assert property (@(posedge clk_i) disable iff (rst_i)
        sel_ext_o || sel_fault_o |-> ($past(ext_mode_i) == sel_ext_o) && !sel_data_o && !sel_rom_o)
        else $error("external routing ignores expansion mode");
    a_high_data_area: assert property (@(posedge clk_i) disable iff (rst_i)
        acc_valid_i && map_is_high |=> sel_data_o == ($past(acc_addr_i) >= CHK_DLO_H))
        else $error("top data window wrong");
    a_high_rom_span: assert property (@(posedge clk_i) disable iff (rst_i)
        acc_valid_i && map_is_high && acc_addr_i <= CHK_RHI_H |=> sel_rom_o)
        else $error("contiguous rom not reachable");
    a_data_priority: assert property (@(posedge clk_i) disable iff (rst_i)
        acc_valid_i && (map_is_high ? (acc_addr_i >= CHK_DLO_H)
                                    : (acc_addr_i >= CHK_DLO_L && acc_addr_i <= `MMD_DHI_L))
        |=> sel_data_o && !sel_rom_o)
        else $error("rom selected over data area");

    // every taken access answers once, one cycle later, and only then
    a_result_follows: assert property (@(posedge clk_i) disable iff (rst_i)
        acc_valid_i |=> out_valid_o && (addr_o == $past(acc_addr_i)))
        else $error("access result missing or wrong address");
    a_idle_quiet: assert property (@(posedge clk_i) disable iff (rst_i)
        !out_valid_o |-> !(sel_data_o || sel_rom_o || sel_ext_o || sel_fault_o))
        else $error("target select without an access");
    a_unset_low: assert property (@(posedge clk_i) disable iff (rst_i)
        !map_done_o |-> !map_high_o)
        else $error("top placement before any selection");

    // rom windows checked against the variant table, not the lookup
    a_low_rom_window: assert property (@(posedge clk_i) disable iff (rst_i)
        s_low_access ##0 (acc_addr_i <= CHK_R0HI_L && acc_addr_i < CHK_DLO_L) |=> sel_rom_o)
        else $error("low rom window missed");
    a_upper_rom_window: assert property (@(posedge clk_i) disable iff (rst_i)
        s_low_access ##0 (CHK_R1_EN && acc_addr_i >= `MMD_R1LO && acc_addr_i <= CHK_R1HI) |=> sel_rom_o)
        else $error("upper rom window missed");
    a_high_rom_limit: assert property (@(posedge clk_i) disable iff (rst_i)
        s_high_access ##0 (acc_addr_i > CHK_RHI_H && acc_addr_i < CHK_DLO_H) |=> !sel_data_o && !sel_rom_o)
        else $error("internal select beyond the rom and data windows");
endmodule : mmd_decoder
`default_nettype wire

// >>> bench/mmd_core_model.sv
// processor core model: issues accesses and mapping selections
`timescale 1ns/10ps
`default_nettype none
module mmd_core_model (
    input  wire logic               clk_i,       // system clock
    output var  logic               acc_valid_o, // access request
    output var  mmd_pkg::mmd_addr_t acc_addr_o,  // access address
    output var  logic               ext_mode_o,  // expansion mode level
    output var  logic               sel_valid_o, // selection pulse
    output var  mmd_pkg::mmd_sel_t  sel_op_o     // selection operand
);
    import mmd_pkg::*;
    // ********************************
    // bus start values
    // ********************************
    initial
    begin
        acc_valid_o = 1'b0;
        acc_addr_o  = 20'h00000;
        ext_mode_o  = 1'b0;
        sel_valid_o = 1'b0;
        sel_op_o    = 4'h0;
    end
    // one access; held until the taking edge, may follow back to back
    task automatic access(input mmd_addr_t a, input logic e);
        acc_valid_o = 1'b1;
        acc_addr_o  = a;
        ext_mode_o  = e;
        @(posedge clk_i);
        #2;
    endtask : access
    // released address toggles, so a stale value never looks real
    task automatic idle();
        acc_valid_o = 1'b0;
        acc_addr_o  = ~acc_addr_o;
        @(posedge clk_i);
        #2;
    endtask : idle
    // one-cycle selection; the bench gives it up to three times per reset
    task automatic select(input mmd_sel_t op);
        acc_valid_o = 1'b0;
        sel_valid_o = 1'b1;
        sel_op_o    = op;
        @(posedge clk_i);
        #2;
        sel_valid_o = 1'b0;
        sel_op_o    = ~op;
        // let an edge pass so a following selection is a fresh pulse
        @(posedge clk_i);
        #2;
    endtask : select
endmodule : mmd_core_model
`default_nettype wire

// >>> bench/internal_memory_map_decoder_test.sv
// self-checking bench: all four variants decode one access stream
`timescale 1ns/10ps
`default_nettype none
module internal_memory_map_decoder_test;
    import mmd_pkg::*;
    logic      clk = 1'b0;   // 40 MHz
    logic      rst;          // synchronous reset
    logic      acc_v;        // access request
    mmd_addr_t acc_a;        // access address
    logic      ext_m;        // expansion mode
    logic      sel_v;        // selection pulse
    mmd_sel_t  sel_op;       // selection operand
    logic      ov[4];        // per-variant result valid
    mmd_addr_t ao[4];        // per-variant result address
    logic      sd[4], sr[4], se[4], sf[4], md[4], mh[4];
    int        miscompares = 0;
    int        total_checks = 0;

    always #12.5 clk = ~clk;

    mmd_core_model i_core (.clk_i(clk), .acc_valid_o(acc_v), .acc_addr_o(acc_a),
        .ext_mode_o(ext_m), .sel_valid_o(sel_v), .sel_op_o(sel_op));
    // ********************************
    // one decoder per variant, same stimulus
    // ********************************
    for (genvar g = 0; g < 4; g++)
    begin : g_var
        mmd_decoder #(.VARIANT(mmd_variant_e'(g))) i_dut (.clk_i(clk), .rst_i(rst),
            .map_sel_valid_i(sel_v), .data_area_map_select_i(sel_op), .acc_valid_i(acc_v),
            .acc_addr_i(acc_a), .ext_mode_i(ext_m), .out_valid_o(ov[g]), .addr_o(ao[g]),
            .sel_data_o(sd[g]), .sel_rom_o(sr[g]), .sel_ext_o(se[g]), .sel_fault_o(sf[g]),
            .map_done_o(md[g]), .map_high_o(mh[g]));
    end
    // expected target {data, rom, ext, fault}; data wins on overlap
    function automatic logic [3:0] exp_sel(input int v, input logic h, input mmd_addr_t a, input logic e);
        mmd_addr_t dl[4] = '{20'h0f700, 20'h0f700, 20'h0f100, 20'h0ee00};
        mmd_addr_t rl[4] = '{20'h0bfff, 20'h0f6ff, 20'h0f0ff, 20'h0fdff};
        mmd_addr_t rh[4] = '{20'h0bfff, 20'h0ffff, 20'h17fff, 20'h1ffff};
        logic      d;
        logic      r;
        d = h ? (a >= {4'hf, dl[v][15:0]}) : (a >= dl[v] && a <= 20'h0ffff);
        r = h ? (a <= rh[v]) : (a <= rl[v] || (v > 1 && a >= 20'h10000 && a <= rh[v]));
        return d ? 4'h8 : (r ? 4'h4 : (e ? 4'h2 : 4'h1));
    endfunction : exp_sel
    // ********************************
    // compares and verdict
    // ********************************
    task automatic chk_dec(input string n, input logic [24:0] e, input logic [24:0] g);
        total_checks++;
        if (g !== e)
        begin
            miscompares++;
            $display("mismatch %s expected %h seen %h", n, e, g);
        end
    endtask : chk_dec
    task automatic chk_map(input string n, input logic [1:0] e, input logic [1:0] g);
        total_checks++;
        if (g !== e)
        begin
            miscompares++;
            $display("mismatch %s expected %b seen %b", n, e, g);
        end
    endtask : chk_map
    task automatic report_and_stop();
        if (miscompares == 0 && total_checks > 0)
            $display("Finished cleanly");
        else
            $display("Finished with errors");
        $finish;
    endtask : report_and_stop
    // reset held four cycles with the core idle
    task automatic do_reset();
        rst = 1'b1;
        repeat (4) @(posedge clk);
        #2;
        rst = 1'b0;
    endtask : do_reset
    // mapping flags {done, high} of every variant
    task automatic check_map(input logic [1:0] e);
        for (int v = 0; v < 4; v++)
            chk_map("map flags", e, {md[v], mh[v]});
    endtask : check_map
    // window boundaries, back to back, both expansion levels, then idle
    task automatic sweep(input logic h);
        mmd_addr_t p[25] = '{20'h00000, 20'h0bfff, 20'h0c000, 20'h0edff, 20'h0ee00, 20'h0f0ff,
            20'h0f100, 20'h0f6ff, 20'h0f700, 20'h0fdff, 20'h0fe00, 20'h0ffff, 20'h10000,
            20'h17fff, 20'h18000, 20'h1ffff, 20'h20000, 20'h80000, 20'hfedff, 20'hfee00,
            20'hff0ff, 20'hff100, 20'hff6ff, 20'hff700, 20'hfffff};
        for (int e = 0; e < 2; e++)
            foreach (p[i])
            begin
                i_core.access(p[i], e[0]);
                for (int v = 0; v < 4; v++)
                    chk_dec("decode", {1'b1, p[i], exp_sel(v, h, p[i], e[0])},
                        {ov[v], ao[v], sd[v], sr[v], se[v], sf[v]});
            end
        i_core.idle();
        for (int v = 0; v < 4; v++)
            chk_dec("idle", 25'h0, {ov[v], 20'h00000, sd[v], sr[v], se[v], sf[v]});
    endtask : sweep
    // ********************************
    // main sequence and watchdog
    // ********************************
    initial
    begin
        do_reset();
        check_map(2'b00);
        sweep(1'b0);
        i_core.select(4'h3);
        check_map(2'b00);
        i_core.select(4'h0);
        check_map(2'b10);
        i_core.select(4'hf);
        check_map(2'b10);
        sweep(1'b0);
        do_reset();
        check_map(2'b00);
        i_core.select(4'hf);
        check_map(2'b11);
        i_core.select(4'h0);
        check_map(2'b11);
        sweep(1'b1);
        report_and_stop();
    end
    // about 170 cycles expected; far more means a hang
    initial
    begin
        #100000;
        miscompares++;
        report_and_stop();
    end
endmodule : internal_memory_map_decoder_test
`default_nettype wire
